// File: rtl/afm_mode_logic.sv
// Async-family line logic for one serial channel: break, isochronous,
// nine-bit and code-violation modes, with a register port for software.
// Assumes synchronous line inputs and bit clock enables from the clk domain.
// Summary of operation
// - Break is framing error plus all-zero data.
// - Break drops character, sets status bit five.
// - Break flags its start only, never end.
// - Break bit clears on write-one and line high.
// - Pin field forces line low, high or normal.
// - Mode 0010 runs one clock per bit.
// - Isochronous sends one or two stop bits.
// - Mode 1000 adds flag bit, one stop.
// - Queue stores address flag with each character.
// - Nine-bit always uses eight data bits, no parity.
// - Nine-bit divisor as in async mode.
// - Received flag one tags block boundary.
// - Mode 0011 runs one clock per bit.
// - Code-violation words open with three-bit start.
// - Code-violation stop count one, two or none.
// - Extended transmit adds eight data bits.
// - Extended receive queues first byte only.
// - Queue stores start type with each word.
// - Receive reports start type at bit eight.
// - NRZ still uses same start bit values.
// - Divisor field gives 16, 32 or 64.
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "afm_cfg.svh"
module afm_mode_logic
  import afm_pkg::*;
#(
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [`AFM_ADDR_W-1:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata_ff,
  input wire logic rxd,
  output logic txd_ff
);
  localparam int PW = $clog2(DEPTH);
  logic [15:0] channel_mode_reg_ff;
  logic [15:0] transmit_mode_reg_ff;
  logic [15:0] receive_mode_reg_ff;
  logic [15:0] io_control_reg_ff;
  logic break_ff;
  afm_txent_t tq_ff [DEPTH];
  afm_rxent_t rq_ff [DEPTH];
  logic [PW:0] tq_wp_ff, tq_rp_ff, rq_wp_ff, rq_rp_ff;
  afm_tx_state_t tx_st_ff;
  afm_rx_state_t rx_st_ff;
  logic [6:0] tx_div_ff, rx_div_ff;
  logic [4:0] tx_cnt_ff, rx_cnt_ff;
  logic [16:0] tx_sh_ff, rx_sh_ff;
  logic tx_tag_ff, tx_line_ff, tx_half_ff;
  logic [1:0] rx_start_ff;
  logic rx_half_ff, rx_prev_ff, rx_second_ff;
  logic tx_bit, rx_bit;

  wire [3:0] tx_mode = channel_mode_reg_ff[11:8];
  wire [3:0] rx_mode = channel_mode_reg_ff[3:0];
  wire tq_full = (tq_wp_ff[PW] != tq_rp_ff[PW]) &&
                 (tq_wp_ff[PW-1:0] == tq_rp_ff[PW-1:0]);
  wire tq_empty = tq_wp_ff == tq_rp_ff;
  wire rq_full = (rq_wp_ff[PW] != rq_rp_ff[PW]) &&
                 (rq_wp_ff[PW-1:0] == rq_rp_ff[PW-1:0]);
  wire rq_empty = rq_wp_ff == rq_rp_ff;

  // Divisor decode shared by both directions; code 11 is reserved and
  // falls back to the slowest rate rather than stopping the channel.
  function automatic logic [6:0] div_of(input logic [1:0] code);
    unique case (code)
      2'b00: div_of = `AFM_DIV16;
      2'b01: div_of = `AFM_DIV32;
      default: div_of = `AFM_DIV64;
    endcase
  endfunction

  function automatic logic one_x(input logic [3:0] m);
    one_x = (m == `AFM_MODE_ISO) || (m == `AFM_MODE_ACV);
  endfunction

  // Data bits per character: length field (0 means 8) plus parity for the
  // async style, and eight more in extended code-violation words.
  function automatic logic [4:0] nbits(input logic [3:0] m,
                                       input logic [15:0] mr,
                                       input logic ext);
    logic [4:0] n;
    n = (mr[4:2] == 3'h0) ? 5'h08 : {2'h0, mr[4:2]};
    if (mr[5]) begin
      n = n + 5'h01;
    end
    if (m == `AFM_MODE_NINE) begin
      n = 5'h08;
    end
    if (m == `AFM_MODE_ACV && ext) begin
      n = n + 5'h08;
    end
    nbits = n;
  endfunction

  // Registers: mode words steer the line logic, status shows its state.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      channel_mode_reg_ff <= `AFM_CMR_RST;
      transmit_mode_reg_ff <= 16'h0000;
      receive_mode_reg_ff <= 16'h0000;
      io_control_reg_ff <= 16'h0000;
    end else if (wr) begin
      unique case (addr)
        `AFM_OFF_CMR: channel_mode_reg_ff <= wdata;
        `AFM_OFF_TMR: transmit_mode_reg_ff <= wdata;
        `AFM_OFF_RMR: receive_mode_reg_ff <= wdata;
        `AFM_OFF_IO_CONTROL_REG: io_control_reg_ff <= wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_ff <= 16'h0000;
    end else if (rd) begin
      unique case (addr)
        `AFM_OFF_CMR: rdata_ff <= channel_mode_reg_ff;
        `AFM_OFF_TMR: rdata_ff <= transmit_mode_reg_ff;
        `AFM_OFF_RMR: rdata_ff <= receive_mode_reg_ff;
        `AFM_OFF_IO_CONTROL_REG: rdata_ff <= io_control_reg_ff;
        `AFM_OFF_RXD: rdata_ff <= {8'h00, rq_ff[rq_rp_ff[PW-1:0]].data};
        `AFM_OFF_RECEIVE_COMMAND_STATUS_REG: begin
          rdata_ff <= 16'h0000;
          rdata_ff[`AFM_RECEIVE_COMMAND_STATUS_REG_CVTYPE] <=
            rq_ff[rq_rp_ff[PW-1:0]].cvtype;
          rdata_ff[`AFM_RECEIVE_COMMAND_STATUS_REG_BREAK] <= break_ff;
          rdata_ff[`AFM_RECEIVE_COMMAND_STATUS_REG_BOUND] <=
            rq_ff[rq_rp_ff[PW-1:0]].bound;
          rdata_ff[`AFM_RECEIVE_COMMAND_STATUS_REG_RXAVAIL] <= !rq_empty;
        end
        default: rdata_ff <= 16'h0000;
      endcase
    end else begin
      rdata_ff <= 16'h0000;
    end
  end

  // Transmit queue: the tag travels with each character. Writes to a full
  // queue are dropped; no status bit shows its fill state to software.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tq_wp_ff <= '0;
    end else if (wr && addr == `AFM_OFF_TXD && !tq_full) begin
      tq_ff[tq_wp_ff[PW-1:0]].data <= wdata[7:0];
      tq_ff[tq_wp_ff[PW-1:0]].tag <= (tx_mode == `AFM_MODE_NINE) ?
        channel_mode_reg_ff[15] : channel_mode_reg_ff[12];
      tq_wp_ff <= tq_wp_ff + 1'b1;
    end
  end

  // Bit-time tick generators.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_div_ff <= 7'h00;
    end else if (tx_bit || tx_st_ff == AFM_TX_IDLE) begin
      tx_div_ff <= 7'h00;
    end else begin
      tx_div_ff <= tx_div_ff + 7'h01;
    end
  end
  always_comb begin
    tx_bit = one_x(tx_mode) ||
             (tx_div_ff == div_of(channel_mode_reg_ff[13:12]) - 7'h01);
  end
  wire tx_last = tx_cnt_ff == nbits(tx_mode, transmit_mode_reg_ff,
                                    channel_mode_reg_ff[13]) - 5'h01;
  wire tx_two = tx_cnt_ff == 5'h00 && channel_mode_reg_ff[14] &&
                tx_mode != `AFM_MODE_NINE;
  wire tx_none = tx_mode == `AFM_MODE_ACV &&
                 channel_mode_reg_ff[15:14] == 2'b10;
  // The next character is fetched in the last cycle of the current one so
  // that back-to-back characters get exactly the programmed stop length.
  wire tx_fetch = tx_st_ff == AFM_TX_IDLE ||
    (tx_st_ff == AFM_TX_DATA && tx_bit && tx_last && tx_none) ||
    (tx_st_ff == AFM_TX_STOP && (tx_none || (tx_bit && !tx_two)));

  // Transmitter. Code-violation start sequences are sent as plain bit
  // values; line encoding lies outside this block.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_st_ff <= AFM_TX_IDLE;
      tq_rp_ff <= '0;
      tx_sh_ff <= '0;
      tx_cnt_ff <= 5'h00;
      tx_tag_ff <= 1'b0;
      tx_line_ff <= 1'b1;
      tx_half_ff <= 1'b0;
    end else begin
      unique case (tx_st_ff)
        AFM_TX_IDLE: begin
          tx_line_ff <= 1'b1;
        end
        AFM_TX_START: begin
          if (tx_mode == `AFM_MODE_ACV) begin
            // Command word 110, data word its inverse: 001.
            tx_line_ff <= (tx_cnt_ff == 5'h02) ? !tx_tag_ff : tx_tag_ff;
          end else begin
            tx_line_ff <= 1'b0;
          end
          if (tx_bit) begin
            if (tx_mode != `AFM_MODE_ACV || tx_cnt_ff == 5'h02) begin
              tx_cnt_ff <= 5'h00;
              tx_st_ff <= AFM_TX_DATA;
            end else begin
              tx_cnt_ff <= tx_cnt_ff + 5'h01;
            end
          end
        end
        AFM_TX_DATA: begin
          tx_line_ff <= tx_sh_ff[0];
          if (tx_bit) begin
            tx_sh_ff <= {1'b0, tx_sh_ff[16:1]};
            if (tx_last) begin
              tx_cnt_ff <= 5'h00;
              tx_st_ff <= (tx_mode == `AFM_MODE_NINE) ? AFM_TX_FLAG
                                                      : AFM_TX_STOP;
            end else begin
              tx_cnt_ff <= tx_cnt_ff + 5'h01;
            end
            // Second byte of an extended word joins on the fly.
            if (tx_mode == `AFM_MODE_ACV && channel_mode_reg_ff[13] &&
                !tx_half_ff && tx_cnt_ff == 5'h07 && !tq_empty) begin
              tx_sh_ff <= {9'h000, tq_ff[tq_rp_ff[PW-1:0]].data};
              tq_rp_ff <= tq_rp_ff + 1'b1;
              tx_half_ff <= 1'b1;
            end
          end
        end
        AFM_TX_FLAG: begin
          tx_line_ff <= tx_tag_ff;
          if (tx_bit) begin
            tx_st_ff <= AFM_TX_STOP;
          end
        end
        AFM_TX_STOP: begin
          tx_line_ff <= 1'b1;
          if (tx_bit && tx_two) begin
            tx_cnt_ff <= 5'h01;
          end
        end
        default: tx_st_ff <= AFM_TX_IDLE;
      endcase
      if (tx_fetch) begin
        tx_cnt_ff <= 5'h00;
        tx_half_ff <= 1'b0;
        if (!tq_empty) begin
          tx_sh_ff <= {9'h000, tq_ff[tq_rp_ff[PW-1:0]].data};
          tx_tag_ff <= tq_ff[tq_rp_ff[PW-1:0]].tag;
          tq_rp_ff <= tq_rp_ff + 1'b1;
          tx_st_ff <= AFM_TX_START;
        end else begin
          tx_st_ff <= AFM_TX_IDLE;
        end
      end
    end
  end

  // Pin control overrides the serial output.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      txd_ff <= 1'b1;
    end else begin
      unique case (io_control_reg_ff[7:6])
        `AFM_PIN_FORCE_LO: txd_ff <= 1'b0;
        `AFM_PIN_FORCE_HI: txd_ff <= 1'b1;
        default: txd_ff <= tx_line_ff;
      endcase
    end
  end

  // Receive timing: 1X modes sample every cycle; oversampled modes sample
  // at mid-bit, having waited half a bit after the start edge.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_div_ff <= 7'h00;
    end else if (rx_bit || rx_st_ff == AFM_RX_IDLE ||
                 rx_st_ff == AFM_RX_BREAK) begin
      rx_div_ff <= 7'h00;
    end else begin
      rx_div_ff <= rx_div_ff + 7'h01;
    end
  end
  always_comb begin
    if (one_x(rx_mode)) begin
      rx_bit = 1'b1;
    end else if (rx_half_ff) begin
      rx_bit = rx_div_ff == (div_of(channel_mode_reg_ff[5:4]) >> 1);
    end else begin
      rx_bit = rx_div_ff == div_of(channel_mode_reg_ff[5:4]) - 7'h01;
    end
  end

  // Receiver with queue write and break latch.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_st_ff <= AFM_RX_IDLE;
      rx_sh_ff <= '0;
      rx_cnt_ff <= 5'h00;
      rx_start_ff <= 2'b00;
      rx_half_ff <= 1'b0;
      rx_prev_ff <= 1'b1;
      rx_second_ff <= 1'b0;
      rq_wp_ff <= '0;
      break_ff <= 1'b0;
    end else begin
      rx_prev_ff <= rxd;
      unique case (rx_st_ff)
        AFM_RX_IDLE: begin
          rx_cnt_ff <= 5'h00;
          rx_sh_ff <= '0;
          if (rx_mode == `AFM_MODE_ACV) begin
            rx_start_ff <= {rx_start_ff[0], rxd};
            // Look for 110 or 001 in the last three line bits.
            if (rx_start_ff == 2'b11 && !rxd ||
                rx_start_ff == 2'b00 && rxd && rx_prev_ff == 1'b0) begin
              rx_second_ff <= rx_start_ff[0];
              rx_st_ff <= AFM_RX_DATA;
            end
          end else if (rx_prev_ff && !rxd) begin
            rx_half_ff <= 1'b1;
            rx_st_ff <= one_x(rx_mode) ? AFM_RX_DATA : AFM_RX_START;
          end
        end
        AFM_RX_START: begin
          if (rx_bit) begin
            rx_half_ff <= 1'b0;
            rx_st_ff <= rxd ? AFM_RX_IDLE : AFM_RX_DATA;
          end
        end
        AFM_RX_DATA: begin
          rx_half_ff <= 1'b0;
          if (rx_bit) begin
            rx_sh_ff[rx_cnt_ff] <= rxd;
            if (rx_cnt_ff == nbits(rx_mode, receive_mode_reg_ff,
                                   channel_mode_reg_ff[4]) - 5'h01) begin
              rx_cnt_ff <= 5'h00;
              rx_st_ff <= (rx_mode == `AFM_MODE_NINE) ? AFM_RX_FLAG
                                                      : AFM_RX_STOP;
            end else begin
              rx_cnt_ff <= rx_cnt_ff + 5'h01;
            end
          end
        end
        AFM_RX_FLAG: begin
          if (rx_bit) begin
            rx_sh_ff[16] <= rxd;
            rx_st_ff <= AFM_RX_STOP;
          end
        end
        AFM_RX_STOP: begin
          if (rx_bit) begin
            // The stop bit is not part of the next start search, so a data
            // word that follows at once is still recognised.
            rx_start_ff <= 2'b00;
            if (!rxd && rx_sh_ff == '0) begin
              break_ff <= 1'b1;
              rx_st_ff <= AFM_RX_BREAK;
            end else begin
              if (!rq_full) begin
                rq_ff[rq_wp_ff[PW-1:0]].data <= rx_sh_ff[7:0];
                rq_ff[rq_wp_ff[PW-1:0]].bound <=
                  (rx_mode == `AFM_MODE_NINE) ? rx_sh_ff[16]
                  : (rx_mode == `AFM_MODE_ACV);
                rq_ff[rq_wp_ff[PW-1:0]].cvtype <= rx_second_ff;
                rq_wp_ff <= rq_wp_ff + 1'b1;
              end
              rx_st_ff <= AFM_RX_IDLE;
            end
          end
        end
        AFM_RX_BREAK: begin
          if (rxd) begin
            rx_st_ff <= AFM_RX_IDLE;
          end
        end
        default: rx_st_ff <= AFM_RX_IDLE;
      endcase
      // The clear only takes once the line is back high; a new break in
      // the same cycle wins.
      if (wr && addr == `AFM_OFF_RECEIVE_COMMAND_STATUS_REG && wdata[`AFM_RECEIVE_COMMAND_STATUS_REG_BREAK] && rxd &&
          !(rx_st_ff == AFM_RX_STOP && rx_bit && !rxd)) begin
        break_ff <= 1'b0;
      end
    end
  end

  // Reading data pops the receive queue.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rq_rp_ff <= '0;
    end else if (rd && addr == `AFM_OFF_RXD && !rq_empty) begin
      rq_rp_ff <= rq_rp_ff + 1'b1;
    end
  end
endmodule // afm_mode_logic
`default_nettype wire

// File: rtl/afm_cfg.svh
// Constants for the async-family mode logic: register offsets, field
// positions, mode codes and timing. Included by the package and design.
`ifndef AFM_CFG_SVH
`define AFM_CFG_SVH
`define AFM_ADDR_W 4
`define AFM_OFF_CMR 4'h0
`define AFM_OFF_TMR 4'h1
`define AFM_OFF_RMR 4'h2
`define AFM_OFF_IO_CONTROL_REG 4'h3
`define AFM_OFF_TXD 4'h4
`define AFM_OFF_RXD 4'h5
`define AFM_OFF_RECEIVE_COMMAND_STATUS_REG 4'h6
`define AFM_MODE_ISO 4'h2
`define AFM_MODE_ACV 4'h3
`define AFM_MODE_NINE 4'h8
`define AFM_RECEIVE_COMMAND_STATUS_REG_CVTYPE 8
`define AFM_RECEIVE_COMMAND_STATUS_REG_BREAK 5
`define AFM_RECEIVE_COMMAND_STATUS_REG_BOUND 4
`define AFM_RECEIVE_COMMAND_STATUS_REG_RXAVAIL 0
`define AFM_PIN_FORCE_LO 2'h2
`define AFM_PIN_FORCE_HI 2'h3
`define AFM_DIV16 7'h10
`define AFM_DIV32 7'h20
`define AFM_DIV64 7'h40
`define AFM_CMR_RST 16'h0000
`endif

// File: rtl/afm_pkg.sv
// Types for the async-family mode logic.
// Assumes afm_cfg.svh is on the include path.
`include "afm_cfg.svh"
package afm_pkg;
  typedef enum logic [2:0] {
    AFM_TX_IDLE = 3'b000,
    AFM_TX_START = 3'b001,
    AFM_TX_DATA = 3'b010,
    AFM_TX_FLAG = 3'b011,
    AFM_TX_STOP = 3'b100
  } afm_tx_state_t;
  typedef enum logic [2:0] {
    AFM_RX_IDLE = 3'b000,
    AFM_RX_START = 3'b001,
    AFM_RX_DATA = 3'b010,
    AFM_RX_FLAG = 3'b011,
    AFM_RX_STOP = 3'b100,
    AFM_RX_BREAK = 3'b101
  } afm_rx_state_t;
  typedef struct packed {
    logic [7:0] data;
    logic tag;
  } afm_txent_t;
  typedef struct packed {
    logic [7:0] data;
    logic bound;
    logic cvtype;
  } afm_rxent_t;
endpackage

// File: verification/afm_remote.sv
// Remote station model: drives the receive line one bit at a time.
// Assumes bit times are whole multiples of the design clock.
`timescale 1ns/1ps
`default_nettype none
module afm_remote (
  input wire logic clk,
  output logic rxd
);
  // The line rests at mark. After a frame it keeps its last bit, so an
  // all-zero frame leaves a held break until the next call releases it.
  initial rxd = 1'b1;
  task automatic send(input logic [23:0] bits, input int n, input int p);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      rxd <= bits[i];
      repeat (p - 1) @(posedge clk);
    end
  endtask
endmodule // afm_remote
`default_nettype wire

// File: verification/afm_mode_chk.sv
// Checker for the async-family mode logic, bound to its top module.
// Assumes register writes and reads follow the one-cycle strobe protocol.
`timescale 1ns/1ps
`default_nettype none
`include "afm_cfg.svh"
module afm_mode_chk
  import afm_pkg::*;
#(
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [`AFM_ADDR_W-1:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata_ff,
  input wire logic rxd,
  input wire logic txd_ff
);
  logic [1:0] pin_ff;
  logic [15:0] cmr_ff;
  logic brk_ff;
  logic rdst_ff;
  logic [3:0] cnt_ff;
  logic iso;
  assign iso = cmr_ff[11:8] == `AFM_MODE_ISO && pin_ff == 2'h0;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_ff <= 2'h0;
      cmr_ff <= `AFM_CMR_RST;
    end else if (wr && addr == `AFM_OFF_IO_CONTROL_REG) begin
      pin_ff <= wdata[7:6];
    end else if (wr && addr == `AFM_OFF_CMR) begin
      cmr_ff <= wdata;
    end
  end
  // Break is known only once software has seen it in a status read.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdst_ff <= 1'b0;
      brk_ff <= 1'b0;
    end else begin
      rdst_ff <= rd && addr == `AFM_OFF_RECEIVE_COMMAND_STATUS_REG;
      if (wr && addr == `AFM_OFF_RECEIVE_COMMAND_STATUS_REG && wdata[5] && rxd) begin
        brk_ff <= 1'b0;
      end else if (rdst_ff && rdata_ff[5]) begin
        brk_ff <= 1'b1;
      end
    end
  end
  // Bit position within an isochronous frame, counted from the start bit.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= 4'h0;
    end else if (!iso) begin
      cnt_ff <= 4'h0;
    end else if (cnt_ff == 4'h0) begin
      cnt_ff <= txd_ff ? 4'h0 : 4'h1;
    end else if (cnt_ff == 4'h9 + {3'h0, cmr_ff[14]}) begin
      cnt_ff <= 4'h0;
    end else begin
      cnt_ff <= cnt_ff + 4'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_rdata_idle: assert property (!$past(rd) |-> rdata_ff == 16'h0000)
    else $error("read data not zero outside read answer");
  a_unmapped_zero: assert property (rd && addr > `AFM_OFF_RECEIVE_COMMAND_STATUS_REG
    |=> rdata_ff == 16'h0000)
    else $error("unmapped read not zero");
  a_pin_low: assert property (
    pin_ff == 2'h2 && $past(pin_ff) == 2'h2 |-> !txd_ff)
    else $error("transmit line not forced low");
  a_pin_high: assert property (
    pin_ff == 2'h3 && $past(pin_ff) == 2'h3 |-> txd_ff)
    else $error("transmit line not forced high");
  a_break_sticky: assert property (
    rd && addr == `AFM_OFF_RECEIVE_COMMAND_STATUS_REG && brk_ff |=> rdata_ff[5])
    else $error("break status lost before release");
  a_break_release: assert property (
    wr && addr == `AFM_OFF_RECEIVE_COMMAND_STATUS_REG && wdata[5] && rxd ##2
    rd && addr == `AFM_OFF_RECEIVE_COMMAND_STATUS_REG |=> !rdata_ff[5])
    else $error("break status not released");
  a_iso_stop_one: assert property (iso && cnt_ff == 4'h9 |-> txd_ff)
    else $error("isochronous stop bit missing");
  a_iso_stop_two: assert property (
    iso && cmr_ff[14] && cnt_ff == 4'hA |-> txd_ff)
    else $error("isochronous second stop bit missing");
  c_iso_two: cover property (iso && cnt_ff == 4'hA);
  c_pin_low: cover property (pin_ff == 2'h2 && !txd_ff);
  c_break: cover property (rd && addr == `AFM_OFF_RECEIVE_COMMAND_STATUS_REG && brk_ff);
endmodule // afm_mode_chk
bind afm_mode_logic afm_mode_chk #(.DEPTH(DEPTH)) u_afm_mode_chk (
  .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata_ff(rdata_ff), .rxd(rxd), .txd_ff(txd_ff));
`default_nettype wire

// File: verification/tb_afm_mode_logic.sv
// Self-checking bench for the async-family mode logic.
// Assumes the design, its checker and the remote line model are compiled.
`timescale 1ns/1ps
`default_nettype none
`include "afm_cfg.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin \
  mismatches++; $display("unexpected at %0t: got %0h exp %0h", \
  $time, g, e); end end
module tb_afm_mode_logic;
  import afm_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic rxd;
  logic txd;
  int mismatches = 0;
  int n_checks = 0;
  logic [15:0] q;
  logic [19:0] b;
  logic [7:0] d1;
  logic [7:0] d2;
  logic [7:0] pv [3] = '{8'h80, 8'hC0, 8'h00};
  always #2 clk = ~clk;
  afm_mode_logic #(.DEPTH(4)) u_afm_mode_logic (.clk(clk), .nrst(nrst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_ff(rdata),
    .rxd(rxd), .txd_ff(txd));
  afm_remote u_afm_remote (.clk(clk), .rxd(rxd));
  task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 q = rdata;
  endtask
  // Status is polled, so a slow receiver never turns into a false mismatch.
  task automatic poll(input int n);
    int k;
    k = 0;
    do begin
      bus(1'b0, `AFM_OFF_RECEIVE_COMMAND_STATUS_REG, 16'h0000);
      k++;
    end while (q[n] !== 1'b1 && k < 400);
  endtask
  task automatic cap(input int p, input int n);
    int k;
    k = 0;
    while (txd !== 1'b0 && k < 3000) begin
      @(posedge clk);
      #1 k++;
    end
    repeat (p / 2) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      repeat (p) @(posedge clk);
      #1 b[i] = txd;
    end
  endtask
  // Two words with a mode write before each; the line is sampled meanwhile.
  task automatic txw(input logic [15:0] c1, input logic [15:0] c2,
                     input int p, input int n);
    d1 = 8'($urandom);
    d2 = 8'($urandom);
    fork
      begin
        bus(1'b1, `AFM_OFF_CMR, c1);
        bus(1'b1, `AFM_OFF_TXD, {8'h00, d1});
        bus(1'b1, `AFM_OFF_CMR, c2);
        bus(1'b1, `AFM_OFF_TXD, {8'h00, d2});
      end
      cap(p, n);
    join
    repeat (12 * p) @(posedge clk);
  endtask
  task automatic rx(input logic [19:0] v, input int n, input int p);
    u_afm_remote.send({4'h0, v}, n, p);
    poll(0);
    `CHK(q[0], 1'b1)
  endtask
  function automatic logic [19:0] nine_exp(logic [7:0] a, logic [7:0] c);
    return {1'b0, c, 1'b0, 1'b1, 1'b1, a};
  endfunction
  function automatic logic [11:0] acv_exp(logic [7:0] a, int st);
    return {st == 0 ? 2'b01 : st == 1 ? 2'b11 : 2'b00, a, 2'b10};
  endfunction
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    stop_test();
  end
  initial begin
    d1 = 8'($urandom(32'hEF81));
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    `CHK(txd, 1'b1)
    bus(1'b0, 4'hF, 16'h0000);
    `CHK(q, 16'h0000)
    bus(1'b0, `AFM_OFF_RECEIVE_COMMAND_STATUS_REG, 16'h0000);
    `CHK(q, 16'h0000)
    bus(1'b0, `AFM_OFF_CMR, 16'h0000);
    `CHK(q, `AFM_CMR_RST)
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, `AFM_OFF_IO_CONTROL_REG, {8'h00, pv[i]});
      @(posedge clk);
      #1 `CHK(txd, i != 0)
    end
    $display("test pin done");
    for (int s = 0; s < 2; s++) begin
      txw({1'b0, 1'(s), 14'h0202}, {1'b0, 1'(s), 14'h0202}, 1, 11);
      `CHK(b[8:0], {1'b1, d1})
      `CHK(b[9], 1'(s))
    end
    $display("test iso tx done");
    for (int i = 0; i < 2; i++) begin
      d1 = i == 0 ? 8'h00 : 8'($urandom);
      rx({10'h000, 1'b1, d1, 1'b0}, 10, 1);
      bus(1'b0, `AFM_OFF_RXD, 16'h0000);
      `CHK(q[7:0], d1)
    end
    u_afm_remote.send(24'h000000, 12, 1);
    poll(5);
    `CHK(q[5:0], 6'h20)
    bus(1'b1, `AFM_OFF_RECEIVE_COMMAND_STATUS_REG, 16'h0020);
    repeat (30) @(posedge clk);
    bus(1'b0, `AFM_OFF_RECEIVE_COMMAND_STATUS_REG, 16'h0000);
    `CHK(q[5:0], 6'h20)
    u_afm_remote.send(24'h000001, 1, 1);
    bus(1'b1, `AFM_OFF_RECEIVE_COMMAND_STATUS_REG, 16'h0020);
    bus(1'b0, `AFM_OFF_RECEIVE_COMMAND_STATUS_REG, 16'h0000);
    `CHK(q[5], 1'b0)
    d1 = 8'($urandom);
    rx({10'h000, 1'b1, d1, 1'b0}, 10, 1);
    bus(1'b0, `AFM_OFF_RXD, 16'h0000);
    `CHK(q[7:0], d1)
    $display("test break done");
    for (int i = 0; i < 3; i++) begin
      txw({2'b10, 2'(i), 6'h20, 2'(i), 4'h8},
          {2'b00, 2'(i), 6'h20, 2'(i), 4'h8}, 16 << i, 20);
      `CHK(b, nine_exp(d1, d2))
    end
    bus(1'b1, `AFM_OFF_CMR, 16'h0808);
    for (int f = 0; f < 2; f++) begin
      d1 = 8'($urandom);
      rx({9'h000, 1'b1, 1'(f), d1, 1'b0}, 11, 16);
      `CHK(q[4], 1'(f))
      bus(1'b0, `AFM_OFF_RXD, 16'h0000);
      `CHK(q[7:0], d1)
    end
    $display("test nine-bit done");
    for (int st = 0; st < 3; st++) begin
      txw({2'(st), 14'h0303}, {2'(st), 14'h0303}, 1, 12);
      `CHK(b[11:0], acv_exp(d1, st))
    end
    txw(16'h1303, 16'h0303, 1, 20);
    `CHK(b, {d2, 4'b1001, d1})
    txw(16'h2303, 16'h2303, 1, 19);
    `CHK(b[18:0], {1'b1, d2, d1, 2'b10})
    bus(1'b1, `AFM_OFF_CMR, 16'h0303);
    // A data word is only recognisable on an NRZ line when it follows the
    // previous word directly, so a command and a data word are streamed.
    d1 = 8'($urandom);
    d2 = 8'($urandom);
    u_afm_remote.send({1'b1, d2, 3'b100, 1'b1, d1, 3'b011}, 24, 1);
    poll(0);
    `CHK(q[8], 1'b1)
    `CHK(q[4], 1'b1)
    bus(1'b0, `AFM_OFF_RXD, 16'h0000);
    `CHK(q[7:0], d1)
    bus(1'b0, `AFM_OFF_RECEIVE_COMMAND_STATUS_REG, 16'h0000);
    `CHK(q[8], 1'b0)
    `CHK(q[4], 1'b1)
    bus(1'b0, `AFM_OFF_RXD, 16'h0000);
    `CHK(q[7:0], d2)
    $display("test code violation done");
    stop_test();
  end
endmodule // tb_afm_mode_logic
`default_nettype wire
